// [common/prom_seq_pkg.sv]
// constants shared by the configuration readout sequencer
`default_nettype none
package prom_seq_pkg;
	// ************************************************************
	// bus map (byte addresses)
	// ************************************************************
	localparam logic [4:0] OFS_CTRL      = 5'h00;
	localparam logic [4:0] OFS_STATUS    = 5'h04;
	localparam logic [4:0] OFS_INSTR     = 5'h08;
	localparam logic [4:0] OFS_PROG_ADDR = 5'h0C;
	localparam logic [4:0] OFS_PROG_DATA = 5'h10;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_PARALLEL = 0;
	localparam int CTRL_CF_ON_D4 = 1;
	localparam int CTRL_SECURITY = 2;
	localparam int CTRL_ISP      = 3;
	localparam int ST_DONE       = 16;
	localparam int ST_STANDBY    = 17;
	localparam int ST_POR_BUSY   = 18;
	localparam int ST_ACTIVE     = 19;
	localparam int IR_ISP_BIT    = 4;
	localparam int IR_SEC_BIT    = 3;
	localparam int D4_BIT        = 4;
	// ************************************************************
	// instruction register
	// ************************************************************
	localparam logic [7:0] IR_RESET      = 8'hFF;
	localparam logic [7:0] IR_CAPTURE    = 8'h01;
	localparam logic [7:0] OP_CONFIG_REQ = 8'hEE;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int CF_PULSE_MIN_NS = 300;
	localparam int CF_PULSE_MAX_NS = 500;
	localparam int CF_CYCLES = (CF_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_HOLD_NS = 1000000;
	localparam int POR_CYCLES = POR_HOLD_NS / CLK_PERIOD_NS;
	// ************************************************************
	// readout states, gray along idle -> stream -> done
	// ************************************************************
	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'h0,
		SEQ_STREAM = 2'h1,
		SEQ_DONE   = 2'h3
	} seq_e;
endpackage
`default_nettype wire

// [src/config_prom_readout_sequencer.sv]
// configuration memory readout sequencer with prefetch fifo and register slave
//
// Operation
// - serial one bit, parallel one byte per clock
// - counters advance on each valid clock edge
// - count to terminal, then hold, float, chain low
// - edge after last word: chain low, float
// - selected downstream device drives and continues stream
// - reset or deselect: address zero, float, chain high
// - chip enable high: standby, address reset, float
// - config instruction pulses request low 300-500ns
// - request may route to bit 4, serial only
// - mode from control register, serial by default
// - power-up holds reset line low about 1ms
// - instruction register eight bits, config opcode EE
// - capture pattern: 01, zero, security, isp, zeros
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`default_nettype none

// ************************************************************
// prefetch fifo
// ************************************************************
module prom_prefetch_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             flush_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);
	if (DEPTH < 2 || WIDTH < 1) $error("fifo depth or width too small");

	logic [WIDTH-1:0] store_r [DEPTH];
	logic [PW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
	logic [PW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	assign in_ready_out  = (cnt_r != FULL);
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out  = store_r[rd_r];
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;

	always_comb
	begin
		wr_nxt  = wr_r;
		rd_nxt  = rd_r;
		cnt_nxt = cnt_r;
		if (flush_in)
		begin
			wr_nxt  = '0;
			rd_nxt  = '0;
			cnt_nxt = '0;
		end
		else
		begin
			if (push)
				wr_nxt = (wr_r == LAST) ? '0 : wr_r + 1'b1;
			if (pop)
				rd_nxt = (rd_r == LAST) ? '0 : rd_r + 1'b1;
			if (push && !pop)
				cnt_nxt = cnt_r + 1'b1;
			else if (pop && !push)
				cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage has no reset: cheaper, and count guards reads
	always_ff @(posedge clk_in)
	begin
		if (push && !flush_in)
			store_r[wr_r] <= in_data_in;
	end
endmodule

// ************************************************************
// sequencer top
// ************************************************************
module config_prom_readout_sequencer #(
	parameter int ADDR_W     = 10,
	parameter int FIFO_DEPTH = 8,
	parameter int POR_CYCLES = prom_seq_pkg::POR_CYCLES
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        config_clock_in,
	input  wire logic        chip_enable_n_in,
	input  wire logic        oe_reset_in,
	output logic             oe_reset_out,
	output logic             oe_reset_oe_n_out,
	output logic      [7:0]  data_out,
	output logic      [7:0]  data_oe_n_out,
	output logic             chain_enable_out_n_out,
	output logic             config_request_n_out
);
	localparam int DEPTH = 2 ** ADDR_W;
	localparam logic [ADDR_W-1:0] TERMINAL_COUNT = '1;
	localparam logic [3:0] CF_LOAD = 4'(prom_seq_pkg::CF_CYCLES);
	localparam logic [2:0] BIT_LAST = 3'h7;
	if (ADDR_W < 1 || ADDR_W > 16) $error("address width out of range");
	if (POR_CYCLES < 1) $error("power-up hold too short");

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [1:0] config_clock_s_r, ce_s_r, oe_s_r;
	logic       config_clock_d_r;
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			config_clock_s_r <= '0;
			ce_s_r   <= 2'h3;
			oe_s_r   <= '0;
			config_clock_d_r <= 1'b0;
		end
		else
		begin
			config_clock_s_r <= {config_clock_s_r[0], config_clock_in};
			ce_s_r   <= {ce_s_r[0], chip_enable_n_in};
			oe_s_r   <= {oe_s_r[0], oe_reset_in};
			config_clock_d_r <= config_clock_s_r[1];
		end
	end
	logic config_clock_rise;
	assign config_clock_rise = config_clock_s_r[1] && !config_clock_d_r;

	// ************************************************************
	// power-up hold of the reset line
	// ************************************************************
	logic [31:0] por_cnt_r, por_cnt_nxt;
	logic        por_busy;
	assign por_busy = (por_cnt_r != 32'(POR_CYCLES));
	always_comb
	begin
		por_cnt_nxt = por_busy ? por_cnt_r + 32'h1 : por_cnt_r;
	end
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			por_cnt_r <= '0;
		else
			por_cnt_r <= por_cnt_nxt;
	end

	// ************************************************************
	// register slave and programming port
	// ************************************************************
	logic              par_r, par_nxt, route_r, route_nxt, sec_r, sec_nxt, isp_r, isp_nxt;
	logic [ADDR_W-1:0] prog_r, prog_nxt;
	logic              wait_r, wait_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [3:0]        cf_cnt_r, cf_cnt_nxt;
	logic              mem_we, bus_req, wr_go;
	logic [7:0]        mem_r [DEPTH];
	logic              active, done;
	logic [ADDR_W-1:0] addr_r;

	assign bus_req = avs_read_in || avs_write_in;
	assign wr_go   = avs_write_in && !wait_r;

	always_comb
	begin
		par_nxt    = par_r;
		route_nxt  = route_r;
		sec_nxt    = sec_r;
		isp_nxt    = isp_r;
		prog_nxt   = prog_r;
		mem_we     = 1'b0;
		rdata_nxt  = rdata_r;
		cf_cnt_nxt = (cf_cnt_r != '0) ? cf_cnt_r - 4'h1 : cf_cnt_r;
		// one wait cycle per access, then release
		wait_nxt   = !(bus_req && wait_r);
		if (bus_req && wait_r)
		begin
			rdata_nxt = '0;
			case (avs_address_in)
				prom_seq_pkg::OFS_CTRL:
				begin
					rdata_nxt[prom_seq_pkg::CTRL_PARALLEL] = par_r;
					rdata_nxt[prom_seq_pkg::CTRL_CF_ON_D4] = route_r;
					rdata_nxt[prom_seq_pkg::CTRL_SECURITY] = sec_r;
					rdata_nxt[prom_seq_pkg::CTRL_ISP]      = isp_r;
				end
				prom_seq_pkg::OFS_STATUS:
				begin
					rdata_nxt[ADDR_W-1:0] = addr_r;
					rdata_nxt[prom_seq_pkg::ST_DONE]     = done;
					rdata_nxt[prom_seq_pkg::ST_STANDBY]  = ce_s_r[1];
					rdata_nxt[prom_seq_pkg::ST_POR_BUSY] = por_busy;
					rdata_nxt[prom_seq_pkg::ST_ACTIVE]   = active;
				end
				prom_seq_pkg::OFS_INSTR:
				begin
					rdata_nxt[7:0] = prom_seq_pkg::IR_CAPTURE;
					rdata_nxt[prom_seq_pkg::IR_SEC_BIT] = sec_r;
					rdata_nxt[prom_seq_pkg::IR_ISP_BIT] = isp_r;
				end
				prom_seq_pkg::OFS_PROG_ADDR: rdata_nxt[ADDR_W-1:0] = prog_r;
				default: rdata_nxt = '0;
			endcase
		end
		if (wr_go)
		begin
			case (avs_address_in)
				prom_seq_pkg::OFS_CTRL:
				begin
					par_nxt   = avs_writedata_in[prom_seq_pkg::CTRL_PARALLEL];
					route_nxt = avs_writedata_in[prom_seq_pkg::CTRL_CF_ON_D4];
					sec_nxt   = avs_writedata_in[prom_seq_pkg::CTRL_SECURITY];
					isp_nxt   = avs_writedata_in[prom_seq_pkg::CTRL_ISP];
				end
				// opcode decode starts the request pulse
				prom_seq_pkg::OFS_INSTR:
				begin
					if (avs_writedata_in[7:0] == prom_seq_pkg::OP_CONFIG_REQ
						&& cf_cnt_r == '0)
						cf_cnt_nxt = CF_LOAD;
				end
				prom_seq_pkg::OFS_PROG_ADDR: prog_nxt = avs_writedata_in[ADDR_W-1:0];
				prom_seq_pkg::OFS_PROG_DATA:
				begin
					mem_we   = 1'b1;
					prog_nxt = prog_r + 1'b1;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			par_r    <= 1'b0;
			route_r  <= 1'b0;
			sec_r    <= 1'b0;
			isp_r    <= 1'b0;
			prog_r   <= '0;
			wait_r   <= 1'b1;
			rdata_r  <= '0;
			cf_cnt_r <= '0;
		end
		else
		begin
			par_r    <= par_nxt;
			route_r  <= route_nxt;
			sec_r    <= sec_nxt;
			isp_r    <= isp_nxt;
			prog_r   <= prog_nxt;
			wait_r   <= wait_nxt;
			rdata_r  <= rdata_nxt;
			cf_cnt_r <= cf_cnt_nxt;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (mem_we)
			mem_r[prog_r] <= avs_writedata_in[7:0];
	end
	assign avs_readdata_out    = rdata_r;
	assign avs_waitrequest_out = wait_r;

	// ************************************************************
	// prefetch and readout sequencer
	// ************************************************************
	prom_seq_pkg::seq_e state_r, state_nxt;
	logic [ADDR_W-1:0]  addr_nxt, fetch_r, fetch_nxt;
	logic [2:0]         bit_r, bit_nxt;
	logic               fetch_done_r, fetch_done_nxt;
	logic               f_in_ready, f_out_valid, pop, unit_last;
	logic [7:0]         head;

	// deselect, reset line low or programming all stop the stream
	assign active    = oe_s_r[1] && !ce_s_r[1] && !por_busy && !isp_r;
	assign done      = (state_r == prom_seq_pkg::SEQ_DONE);
	assign unit_last = par_r || (bit_r == BIT_LAST);
	assign pop       = (state_r == prom_seq_pkg::SEQ_STREAM) && config_clock_rise
		&& f_out_valid && unit_last;

	// a stall here only starves readout if the link outruns the clock
	prom_prefetch_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in        (sys_clk_in),
		.rst_n_in      (rst_n_in),
		.flush_in      (!active),
		.in_valid_in   (active && !fetch_done_r),
		.in_data_in    (mem_r[fetch_r]),
		.in_ready_out  (f_in_ready),
		.out_valid_out (f_out_valid),
		.out_data_out  (head),
		.out_ready_in  (pop)
	);

	always_comb
	begin
		state_nxt      = state_r;
		addr_nxt       = addr_r;
		bit_nxt        = bit_r;
		fetch_nxt      = fetch_r;
		fetch_done_nxt = fetch_done_r;
		if (active && !fetch_done_r && f_in_ready)
		begin
			fetch_done_nxt = (fetch_r == TERMINAL_COUNT);
			fetch_nxt      = fetch_r + 1'b1;
		end
		case (state_r)
			prom_seq_pkg::SEQ_IDLE: state_nxt = prom_seq_pkg::SEQ_STREAM;
			prom_seq_pkg::SEQ_STREAM:
			begin
				if (config_clock_rise && f_out_valid)
				begin
					// byte per edge, or bit per edge
					bit_nxt = unit_last ? 3'h0 : bit_r + 3'h1;
					if (unit_last)
					begin
						if (addr_r == TERMINAL_COUNT)
							state_nxt = prom_seq_pkg::SEQ_DONE;
						else
							addr_nxt = addr_r + 1'b1;
					end
				end
			end
			prom_seq_pkg::SEQ_DONE: state_nxt = prom_seq_pkg::SEQ_DONE;
			default: state_nxt = prom_seq_pkg::SEQ_IDLE;
		endcase
		// address returns to zero only here; bit and fetch counters also wrap
		if (!active)
		begin
			state_nxt      = prom_seq_pkg::SEQ_IDLE;
			addr_nxt       = '0;
			bit_nxt        = '0;
			fetch_nxt      = '0;
			fetch_done_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_r      <= prom_seq_pkg::SEQ_IDLE;
			addr_r       <= '0;
			bit_r        <= '0;
			fetch_r      <= '0;
			fetch_done_r <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			addr_r       <= addr_nxt;
			bit_r        <= bit_nxt;
			fetch_r      <= fetch_nxt;
			fetch_done_r <= fetch_done_nxt;
		end
	end

	// ************************************************************
	// pin drivers
	// ************************************************************
	logic [7:0] dout_nxt, doe_n_nxt;
	logic       ceo_nxt, cf_n_nxt, drive, d4_routed;

	always_comb
	begin
		drive     = (state_r == prom_seq_pkg::SEQ_STREAM);
		cf_n_nxt  = (cf_cnt_r == '0);
		d4_routed = route_r && !par_r;
		dout_nxt  = par_r ? head : {7'h00, head[BIT_LAST - bit_r]};
		doe_n_nxt = par_r ? {8{!drive}} : {7'h7F, !drive};
		if (d4_routed)
		begin
			dout_nxt[prom_seq_pkg::D4_BIT]  = cf_n_nxt;
			doe_n_nxt[prom_seq_pkg::D4_BIT] = 1'b0;
		end
		// chain goes low only past terminal count
		ceo_nxt = !done;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			data_out               <= '0;
			data_oe_n_out          <= 8'hFF;
			chain_enable_out_n_out <= 1'b1;
			config_request_n_out   <= 1'b1;
			oe_reset_out           <= 1'b0;
			oe_reset_oe_n_out      <= 1'b0;
		end
		else
		begin
			data_out               <= dout_nxt;
			data_oe_n_out          <= doe_n_nxt;
			chain_enable_out_n_out <= ceo_nxt;
			config_request_n_out   <= cf_n_nxt;
			oe_reset_out           <= 1'b0;
			// release to the pull-up after the hold
			oe_reset_oe_n_out      <= !por_busy;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	a_deselect_float: assert property (!active |=> ##1 (data_oe_n_out[0] && chain_enable_out_n_out))
		else $error("deselected device still drives");
	a_standby_addr: assert property (ce_s_r[1] |=> (addr_r == '0 && state_r == prom_seq_pkg::SEQ_IDLE))
		else $error("standby without address reset");
	a_parallel_step: assert property ((pop && par_r && addr_r != TERMINAL_COUNT) |=> addr_r == $past(addr_r) + 1'b1)
		else $error("parallel edge did not step address");
	a_serial_hold: assert property ((config_clock_rise && f_out_valid && !par_r && bit_r != BIT_LAST && state_r == prom_seq_pkg::SEQ_STREAM) |=> (addr_r == $past(addr_r) && bit_r == $past(bit_r) + 3'h1))
		else $error("serial bit counter misstepped");
	a_terminal_hold: assert property ((done && active) |=> (done && addr_r == TERMINAL_COUNT))
		else $error("address moved past terminal count");
	a_last_float: assert property ((pop && addr_r == TERMINAL_COUNT) |=> ##1 (!chain_enable_out_n_out && data_oe_n_out[0]))
		else $error("chain output not asserted after last word");
	a_stream_drive: assert property ((state_r == prom_seq_pkg::SEQ_STREAM) |=> !data_oe_n_out[0])
		else $error("selected device not driving");
	a_request_pulse: assert property ($fell(config_request_n_out) |-> (!config_request_n_out)[*8] ##1 config_request_n_out)
		else $error("request pulse width wrong");
	a_request_idle: assert property ((cf_cnt_r == '0) |=> config_request_n_out)
		else $error("request low outside pulse");
	a_por_release: assert property ($fell(por_busy) |=> ##[0:1] oe_reset_oe_n_out)
		else $error("reset line not released");
	a_d4_parallel: assert property ((par_r && $past(par_r) && drive) |=> !data_oe_n_out[prom_seq_pkg::D4_BIT])
		else $error("bit four not data in parallel mode");
endmodule
`default_nettype wire

// [verification/config_prom_readout_sequencer_tb_top.sv]
// self-checking bench for the configuration readout sequencer
`default_nettype none
`define CHK(got, exp) \
	begin samples_checked++; if ((got) !== (exp)) begin failures++; \
	$display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module config_prom_readout_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// short counts keep the run small
	localparam int AW   = 4;
	localparam int PORC = 20;
	logic        sys_clk     = 1'b0;
	logic        rst_n       = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read    = 1'b0;
	logic        avs_write   = 1'b0;
	logic [31:0] avs_wdata   = 32'h0;
	logic [31:0] avs_rdata;
	logic        avs_wait;
	logic        config_clock;
	logic        ce_n;
	logic        oe_line;
	logic        oe_hold_n;
	logic        oe_drv;
	logic [7:0]  dout;
	logic [7:0]  dout_oe_n;
	logic [7:0]  bus_data;
	logic        chain_n;
	logic        req_n;
	logic [31:0] rd;
	logic [7:0]  eb;
	int          failures = 0;
	int          samples_checked = 0;
	int          nrq;
	int          nb4;
	initial forever #20 sys_clk = ~sys_clk;
	config_prom_readout_sequencer #(.ADDR_W(AW), .FIFO_DEPTH(8), .POR_CYCLES(PORC)) u_dut (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n), .avs_address_in(avs_address),
		.avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_wdata),
		.avs_readdata_out(avs_rdata), .avs_waitrequest_out(avs_wait),
		.config_clock_in(config_clock), .chip_enable_n_in(ce_n), .oe_reset_in(oe_line),
		.oe_reset_out(oe_drv), .oe_reset_oe_n_out(oe_hold_n), .data_out(dout),
		.data_oe_n_out(dout_oe_n), .chain_enable_out_n_out(chain_n),
		.config_request_n_out(req_n));
	fpga_config_port_model u_fpga (
		.clk_in(sys_clk), .data_in(dout), .data_oe_n_in(dout_oe_n),
		.oe_reset_oe_n_in(oe_hold_n), .config_clock_out(config_clock), .chip_enable_n_out(ce_n),
		.oe_reset_line_out(oe_line), .data_bus_out(bus_data));
	// ************************************************************
	// bus and helper tasks
	// ************************************************************
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		avs_address <= a;
		avs_wdata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		// no local limit: only the watchdog ends a wait that never comes
		do
			@(posedge sys_clk);
		while (avs_wait !== 1'b0);
		rd = avs_rdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	function automatic logic [7:0] exp_byte(input int i);
		return 8'hA5 + 8'(i) * 8'h13;
	endfunction
	// a pulse is counted on the request pin and on the routed bit 4 line
	task automatic count_pulse();
		nrq = 0;
		nb4 = 0;
		bus(1'b1, prom_seq_pkg::OFS_INSTR, 32'h0000_00EE);
		repeat (30)
		begin
			@(negedge sys_clk);
			nrq += int'(req_n === 1'b0);
			nb4 += int'(bus_data[4] === 1'b0);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		conclude();
	end
	// ************************************************************
	// test sequence
	// ************************************************************
	initial
	begin
		settle(1);
		`CHK({dout_oe_n, chain_n, req_n, oe_hold_n}, 11'h7FE);
		repeat (9) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(1'b0, prom_seq_pkg::OFS_STATUS, 32'h0);
		`CHK({rd[18], oe_line, oe_drv}, 3'h4);
		bus(1'b0, prom_seq_pkg::OFS_CTRL, 32'h0);
		`CHK(rd, 32'h0000_0000);
		bus(1'b0, prom_seq_pkg::OFS_INSTR, 32'h0);
		`CHK(rd[7:0], 8'h01);
		bus(1'b1, prom_seq_pkg::OFS_CTRL, 32'h0000_0004);
		bus(1'b0, prom_seq_pkg::OFS_INSTR, 32'h0);
		`CHK(rd[7:0], 8'h09);
		bus(1'b1, prom_seq_pkg::OFS_CTRL, 32'h0000_0008);
		bus(1'b0, prom_seq_pkg::OFS_INSTR, 32'h0);
		`CHK(rd[7:0], 8'h11);
		bus(1'b1, prom_seq_pkg::OFS_CTRL, 32'h0000_0000);
		bus(1'b0, 5'h14, 32'h0);
		`CHK(rd, 32'h0000_0000);
		bus(1'b1, prom_seq_pkg::OFS_PROG_ADDR, 32'h0);
		for (int i = 0; i < 2 ** AW; i++)
			bus(1'b1, prom_seq_pkg::OFS_PROG_DATA, {24'h0, exp_byte(i)});
		settle(PORC + 10);
		`CHK({oe_hold_n, oe_line, oe_drv}, 3'h6);
		$display("test power_up_and_registers done");
		bus(1'b1, prom_seq_pkg::OFS_CTRL, 32'h0000_0001);
		u_fpga.set_lines(1'b1, 1'b0);
		settle(10);
		`CHK(dout_oe_n, 8'h00);
		for (int i = 0; i < 2 ** AW; i++)
		begin
			`CHK({chain_n, bus_data}, {1'b1, exp_byte(i)});
			u_fpga.config_clock_edge();
			@(negedge sys_clk);
		end
		`CHK({chain_n, dout_oe_n}, 9'h0FF);
		u_fpga.config_clock_edge();
		settle(1);
		`CHK({chain_n, dout_oe_n}, 9'h0FF);
		bus(1'b0, prom_seq_pkg::OFS_STATUS, 32'h0);
		`CHK({rd[19], rd[16], rd[AW-1:0]}, 6'h3F);
		u_fpga.set_lines(1'b1, 1'b1);
		settle(10);
		`CHK({chain_n, dout_oe_n}, 9'h1FF);
		bus(1'b0, prom_seq_pkg::OFS_STATUS, 32'h0);
		`CHK({rd[17], rd[AW-1:0]}, 5'h10);
		$display("test parallel_readout done");
		bus(1'b1, prom_seq_pkg::OFS_CTRL, 32'h0000_0000);
		u_fpga.set_lines(1'b1, 1'b0);
		settle(10);
		`CHK(dout_oe_n, 8'hFE);
		for (int b = 0; b < 2; b++)
		begin
			eb = exp_byte(b);
			for (int k = 7; k >= 0; k--)
			begin
				`CHK(bus_data[0], eb[k]);
				u_fpga.config_clock_edge();
				@(negedge sys_clk);
			end
		end
		u_fpga.set_lines(1'b0, 1'b0);
		settle(10);
		`CHK({chain_n, dout_oe_n}, 9'h1FF);
		bus(1'b0, prom_seq_pkg::OFS_STATUS, 32'h0);
		`CHK(rd[AW-1:0], 4'h0);
		u_fpga.set_lines(1'b1, 1'b1);
		$display("test serial_readout done");
		bus(1'b1, prom_seq_pkg::OFS_CTRL, 32'h0000_0002);
		count_pulse();
		`CHK(nrq, 8);
		`CHK(nb4, 8);
		bus(1'b1, prom_seq_pkg::OFS_CTRL, 32'h0000_0003);
		count_pulse();
		`CHK(nrq, 8);
		`CHK(nb4, 0);
		`CHK(req_n, 1'b1);
		$display("test config_request done");
		conclude();
	end
endmodule
`default_nettype wire

// [verification/fpga_config_port_model.sv]
// fpga configuration port model facing the readout sequencer
`default_nettype none
module fpga_config_port_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] data_in,
	input  wire logic [7:0] data_oe_n_in,
	input  wire logic       oe_reset_oe_n_in,
	output logic            config_clock_out,
	output logic            chip_enable_n_out,
	output logic            oe_reset_line_out,
	output logic      [7:0] data_bus_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// fpga side lines
	// ************************************************************
	logic init_n_r = 1'b1;
	logic done_r   = 1'b1;
	initial config_clock_out = 1'b0;
	assign chip_enable_n_out = done_r;
	assign oe_reset_line_out = init_n_r & oe_reset_oe_n_in;
	// shared data lines, released bits pulled up
	assign data_bus_out = data_in | data_oe_n_in;
	// clock idles low outside frames; 13-cycle period covers the sync lag
	task automatic config_clock_edge();
		@(posedge clk_in);
		config_clock_out <= 1'b1;
		repeat (6) @(posedge clk_in);
		config_clock_out <= 1'b0;
		repeat (6) @(posedge clk_in);
	endtask
	task automatic set_lines(input logic init_n, input logic done);
		@(posedge clk_in);
		init_n_r <= init_n;
		done_r <= done;
	endtask
endmodule
`default_nettype wire
